// ==== lsc_params.svh ====
// Purpose: Constants for the display RAM addressing and line scan block
// Assumes: 50 MHz system clock, Avalon-MM register access
// Notes: Offsets are byte addresses on a 32-bit bus
//
// Behaviour
// - Hold a 6-bit start line that picks the row shown on first common output.
// - Changing the start line scrolls the picture vertically.
// - Frame marker high presets line counter; falling line pulse increments it.
// - Line counter addresses 128-bit rows read one after another for the driver.
// - RAM is 128 by 67 bits, host accesses one byte at X and Y.
// - Auto-increment X and/or Y after each host RAM read or write when enabled.
// - X address values 10H to FFH are refused.
// - Y address values 43H to FFH are refused.
// - Latch row on line pulse rising edge, drive it out on falling edge.
// - Line counter follows LCD timing, independent of host X and Y counters.
// - Each RAM bit drives exactly one dot; rows 40H to 42H are never read by the display port and drive none.
// - Invert flag 0 lights dots for ones; flag 1 reverses polarity.
// - Segment-order flag mirrors column mapping onto segment outputs.
// - Icon mode drives two icon terminals for one icon, independent of others.
// - Icon clock comes from internal divider or the external clock input.
// - Graphic RAM uses X 00H to 0FH and Y 00H to 3FH.
// - Y 40H to 42H reach the segment-mode memory rows.
`ifndef LSC_PARAMS_SVH
`define LSC_PARAMS_SVH

`define LSC_REG_CTRL    5'h00
`define LSC_REG_START   5'h04
`define LSC_REG_XADDR   5'h08
`define LSC_REG_YADDR   5'h0C
`define LSC_REG_DATA    5'h10
`define LSC_REG_STATUS  5'h14

`define LSC_CTRL_INV    0
`define LSC_CTRL_REV    1
`define LSC_CTRL_SWAP   2
`define LSC_CTRL_XINC   3
`define LSC_CTRL_YINC   4
`define LSC_CTRL_ICON   5
`define LSC_CTRL_EXTCK  6
`define LSC_CTRL_ICONON 7
`define LSC_CTRL_RESET  8'h00

`define LSC_X_LIMIT     8'h10
`define LSC_Y_LIMIT     8'h43
`define LSC_Y_LAST      7'h42
`define LSC_X_ONE       4'h1
`define LSC_Y_ONE       7'h01
`define LSC_LINE_ONE    6'h01
`define LSC_RAM_ROWS    67
`define LSC_ROW_BITS    128
`define LSC_BYTES_ROW   16

`define LSC_CLK_HZ      50000000
`define LSC_ICON_HZ     120

`endif

// ==== lsc_pkg.sv ====
// Purpose: Types for the display RAM addressing and line scan block
// Assumes: lsc_params.svh supplies the numeric constants
// Notes: One packed struct carries all state of the top module
package lsc_pkg;

  typedef struct packed {
    logic         wait_q;
    logic [31:0]  rdata;
    logic [7:0]   ctrl;
    logic [5:0]   start;
    logic [3:0]   x;
    logic [6:0]   y;
    logic [7:0]   rd_buf;
    logic [5:0]   line;
    logic [1:0]   fm_s;
    logic [1:0]   lp_s;
    logic         lp_prev;
    logic [1:0]   exa_s;
    logic [17:0]  div;
    logic         ph;
    logic         icon_a;
    logic         icon_b;
    logic         first_common_output;
    logic [127:0] latch;
    logic [127:0] seg;
  } lsc_state_t;

endpackage

// ==== lsc_ram.sv ====
// Purpose: Display memory, graphic rows plus segment-mode rows
// Assumes: Caller only presents valid X and Y addresses
// Notes: Host read is combinational, display read is registered
`timescale 1ns/1ns
`include "lsc_params.svh"

module lsc_ram
(
  input  wire logic         clk,
  input  wire logic         host_we,
  input  wire logic [3:0]   host_x,
  input  wire logic [6:0]   host_y,
  input  wire logic [7:0]   host_wbyte,
  output logic      [7:0]   host_rbyte,
  input  wire logic [5:0]   disp_line,
  output logic      [127:0] disp_row
);

  // Rows 40H..42H sit above the 64 graphic rows
  logic [`LSC_ROW_BITS-1:0] mem [0:`LSC_RAM_ROWS-1];
  logic [6:0]               bit_base;

  assign bit_base   = {host_x, 3'h0};
  assign host_rbyte = mem[host_y][bit_base +: 8];

  always_ff @(posedge clk)
  begin
    if (host_we)
    begin
      mem[host_y][bit_base +: 8] <= host_wbyte;
    end
    // Display port only ever reaches the graphic rows
    disp_row <= mem[{1'b0, disp_line}];
  end

endmodule

// ==== lsc_scan.sv ====
// Purpose: Host RAM addressing, line counter, row latch and segment mapping
// Assumes: Frame marker, line pulse and external clock arrive asynchronously
// Notes: Registers reached over Avalon-MM, one wait cycle per access
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`include "lsc_params.svh"

module lsc_scan
#(
  parameter int ICON_HALF = `LSC_CLK_HZ / (2 * `LSC_ICON_HZ)
)
(
  input  wire logic         CLK_SYS,
  input  wire logic         RST_N,
  input  wire logic [4:0]   AVS_ADDRESS,
  input  wire logic         AVS_READ,
  input  wire logic         AVS_WRITE,
  input  wire logic [31:0]  AVS_WRITEDATA,
  input  wire logic [3:0]   AVS_BYTEENABLE,
  output logic      [31:0]  AVS_READDATA,
  output logic              AVS_WAITREQUEST,
  input  wire logic         FRAME_MARKER,
  input  wire logic         LINE_PULSE,
  input  wire logic         EXTERNAL_DISPLAY_CLOCK_IN,
  output logic      [127:0] SEGMENT_OUTPUTS,
  output logic              FIRST_COMMON_OUTPUT,
  output logic      [5:0]   LINE_ADDRESS,
  output logic              ICON_OUT_A,
  output logic              ICON_OUT_B
);

  localparam logic [17:0] ICON_LAST = 18'(ICON_HALF - 1);

  lsc_pkg::lsc_state_t s;
  lsc_pkg::lsc_state_t d;

  logic         ram_we;
  logic [7:0]   ram_rbyte;
  logic [127:0] disp_row;
  logic [127:0] mapped;
  logic         lp_rise;
  logic         lp_fall;
  logic         access;
  logic         step;
  logic         icon_src;

  lsc_ram u_ram
  (
    .clk        (CLK_SYS),
    .host_we    (ram_we),
    .host_x     (s.x),
    .host_y     (s.y),
    .host_wbyte (AVS_WRITEDATA[7:0]),
    .host_rbyte (ram_rbyte),
    .disp_line  (s.line),
    .disp_row   (disp_row)
  );

  // One latch bit per dot; order and polarity chosen at run time
  genvar g;
  generate
    for (g = 0; g < `LSC_ROW_BITS; g++)
    begin : g_map
      localparam int B = g / 8;
      localparam int J = g % 8;
      logic [3:0] col;
      logic [2:0] bsel;
      assign col  = s.ctrl[`LSC_CTRL_REV] ? 4'(`LSC_BYTES_ROW - 1 - B) : 4'(B);
      assign bsel = s.ctrl[`LSC_CTRL_SWAP] ? 3'(7 - J) : 3'(J);
      assign mapped[g] = s.ctrl[`LSC_CTRL_INV] ^ s.latch[{col, bsel}];
    end
  endgenerate

  always_comb
  begin
    d        = s;
    ram_we   = 1'b0;
    access   = 1'b0;
    step     = 1'b0;
    // Only the second stage of each synchroniser is looked at
    d.fm_s   = {s.fm_s[0], FRAME_MARKER};
    d.lp_s   = {s.lp_s[0], LINE_PULSE};
    d.exa_s  = {s.exa_s[0], EXTERNAL_DISPLAY_CLOCK_IN};
    d.lp_prev = s.lp_s[1];
    lp_rise  = s.lp_s[1] & ~s.lp_prev;
    lp_fall  = ~s.lp_s[1] & s.lp_prev;

    // Line counter never looks at the host address counters
    if (s.fm_s[1])
    begin
      d.line = s.start;
    end
    else if (lp_fall)
    begin
      d.line = s.line + `LSC_LINE_ONE;
    end

    if (lp_rise)
    begin
      d.latch = disp_row;
    end
    if (lp_fall)
    begin
      d.seg  = mapped;
      d.first_common_output = (s.line == s.start);
    end

    // Icon clock source and two-terminal drive
    icon_src = s.ph;
    if (s.div == ICON_LAST)
    begin
      d.div = 18'h00000;
      d.ph  = ~s.ph;
    end
    else
    begin
      d.div = s.div + 18'h00001;
    end
    if (s.ctrl[`LSC_CTRL_EXTCK])
    begin
      icon_src = s.exa_s[1];
    end
    if (s.ctrl[`LSC_CTRL_ICON])
    begin
      // Opposite phase across the icon lights it, same phase keeps it dark
      d.icon_a = icon_src;
      d.icon_b = s.ctrl[`LSC_CTRL_ICONON] ? ~icon_src : icon_src;
    end
    else
    begin
      d.icon_a = 1'b0;
      d.icon_b = 1'b0;
    end

    // Bus slave: answer one cycle after the request is seen
    d.wait_q = 1'b1;
    if ((AVS_READ || AVS_WRITE) && s.wait_q)
    begin
      access   = 1'b1;
      d.wait_q = 1'b0;
      d.rdata  = 32'h00000000;
    end

    if (access && AVS_WRITE && AVS_BYTEENABLE[0])
    begin
      unique case (AVS_ADDRESS)
        `LSC_REG_CTRL:
        begin
          d.ctrl = AVS_WRITEDATA[7:0];
        end
        `LSC_REG_START:
        begin
          d.start = AVS_WRITEDATA[5:0];
        end
        `LSC_REG_XADDR:
        begin
          if (AVS_WRITEDATA[7:0] < `LSC_X_LIMIT)
          begin
            d.x = AVS_WRITEDATA[3:0];
          end
        end
        `LSC_REG_YADDR:
        begin
          if (AVS_WRITEDATA[7:0] < `LSC_Y_LIMIT)
          begin
            d.y = AVS_WRITEDATA[6:0];
          end
        end
        `LSC_REG_DATA:
        begin
          ram_we = 1'b1;
          step   = 1'b1;
        end
        default:
        begin
        end
      endcase
    end

    if (access && AVS_READ)
    begin
      unique case (AVS_ADDRESS)
        `LSC_REG_CTRL:
        begin
          d.rdata = {24'h000000, s.ctrl};
        end
        `LSC_REG_START:
        begin
          d.rdata = {26'h0000000, s.start};
        end
        `LSC_REG_XADDR:
        begin
          d.rdata = {28'h0000000, s.x};
        end
        `LSC_REG_YADDR:
        begin
          d.rdata = {25'h0000000, s.y};
        end
        `LSC_REG_DATA:
        begin
          // Data comes one access late, hence the dummy read
          d.rdata  = {24'h000000, s.rd_buf};
          d.rd_buf = ram_rbyte;
          step     = 1'b1;
        end
        `LSC_REG_STATUS:
        begin
          d.rdata = {23'h000000, s.ph, s.fm_s[1], s.lp_s[1], s.line};
        end
        default:
        begin
        end
      endcase
    end

    if (step && s.ctrl[`LSC_CTRL_XINC])
    begin
      d.x = s.x + `LSC_X_ONE;
    end
    if (step && s.ctrl[`LSC_CTRL_YINC])
    begin
      d.y = (s.y >= `LSC_Y_LAST) ? 7'h00 : s.y + `LSC_Y_ONE;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_N)
    begin
      s        <= '0;
      s.wait_q <= 1'b1;
      s.ctrl   <= `LSC_CTRL_RESET;
    end
    else
    begin
      s <= d;
    end
  end

  assign AVS_READDATA        = s.rdata;
  assign AVS_WAITREQUEST     = s.wait_q;
  assign SEGMENT_OUTPUTS     = s.seg;
  assign FIRST_COMMON_OUTPUT = s.first_common_output;
  assign LINE_ADDRESS        = s.line;
  assign ICON_OUT_A          = s.icon_a;
  assign ICON_OUT_B          = s.icon_b;

  a_fm_preset_line: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    s.fm_s[1] |=> (s.line == $past(s.start)))
    else $error("line counter not preset from start line");

  a_lp_fall_count: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!s.fm_s[1] && lp_fall) |=> (s.line == $past(s.line) + 6'h01))
    else $error("line counter did not advance modulo 64");

  a_line_holds_still: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (!s.fm_s[1] && !lp_fall) |=> $stable(s.line))
    else $error("line counter moved without timing event");

  a_latch_on_rise: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lp_rise |=> (s.latch == $past(disp_row)))
    else $error("row not latched on line pulse rise");

  a_out_on_fall: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    lp_fall |=> (s.seg == $past(mapped)) ##1 $stable(s.seg))
    else $error("segment outputs not updated on line pulse fall");

  a_x_refused: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (access && AVS_WRITE && AVS_ADDRESS == `LSC_REG_XADDR && AVS_WRITEDATA[7:0] >= `LSC_X_LIMIT)
    |=> $stable(s.x))
    else $error("invalid X address accepted");

  a_y_refused: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (access && AVS_WRITE && AVS_ADDRESS == `LSC_REG_YADDR && AVS_WRITEDATA[7:0] >= `LSC_Y_LIMIT)
    |=> $stable(s.y))
    else $error("invalid Y address accepted");

  a_x_auto_inc: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (access && AVS_ADDRESS == `LSC_REG_DATA && s.ctrl[`LSC_CTRL_XINC])
    |=> (s.x == $past(s.x) + 4'h1))
    else $error("X address did not auto increment");

  a_bus_answer: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ((AVS_READ || AVS_WRITE) && s.wait_q) |=> !s.wait_q ##1 s.wait_q)
    else $error("bus answer not one cycle wide");

  a_icon_idle_low: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !s.ctrl[`LSC_CTRL_ICON] |=> (!s.icon_a && !s.icon_b))
    else $error("icon terminals driven while icon mode off");

endmodule

// ==== lsc_lcd_src.sv ====
// Purpose: Timing source model driving frame marker, line pulse, icon clock
// Assumes: One line per go pulse, 14 system clocks long
// Notes: Line timing scaled down, icon clock runs free
`timescale 1ns/1ns

module lsc_lcd_src
(
  input  wire logic clk,
  input  wire logic go,
  input  wire logic frm,
  output logic      fm,
  output logic      lp,
  output logic      external_display_clock_in
);
  int   c = 99;
  int   e = 0;
  logic f = 1'b0;
  logic fm_r = 1'b0;
  logic lp_r = 1'b0;
  logic exa_r = 1'b0;

  assign fm  = fm_r;
  assign lp  = lp_r;
  assign external_display_clock_in = exa_r;

  // Marker leads the pulse so the preset settles before the row latch
  always @(posedge clk)
  begin
    c <= go ? 0 : (c < 99 ? c + 1 : c);
    f <= go ? frm : f;
    fm_r <= f && (c < 14);
    lp_r <= (c >= 4) && (c < 10);
    e <= (e == 2) ? 0 : e + 1;
    if (e == 2)
      exa_r <= ~exa_r;
  end
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the scan block
// Assumes: Avalon slave answers after its own wait state
// Notes: Icon divider shortened to 4 clocks
`timescale 1ns/1ns
`include "lsc_params.svh"

module tb_top;
  typedef struct {logic [4:0] a; logic [31:0] d; logic [31:0] e;} lsc_row_t;
  logic         clk, rst_n, rd, wr, go, frm, fm, lp, external_display_clock_in, wait_o, first_common_output, ia, ib;
  logic [4:0]   addr;
  logic [31:0]  wd, rdata, q;
  logic [127:0] seg;
  logic [5:0]   line;
  int           err_total, checked;
  lsc_row_t     rows[7] = '{'{`LSC_REG_CTRL, 32'hFFFFFF18, 32'h18},
    '{`LSC_REG_START, 32'h3F, 32'h3F}, '{`LSC_REG_XADDR, 32'h0F, 32'h0F},
    '{`LSC_REG_XADDR, 32'h10, 32'h0F}, '{`LSC_REG_YADDR, 32'h42, 32'h42},
    '{`LSC_REG_YADDR, 32'h43, 32'h42}, '{5'h18, 32'h55, 32'h0}};
  logic [7:0]   mc[4] = '{8'h01, 8'h02, 8'h04, 8'h06};
  logic [127:0] me[4] = '{~128'h1, 128'h1 << 120, 128'h1 << 7, 128'h1 << 127};

  lsc_scan #(.ICON_HALF(4)) DUT (.CLK_SYS(clk), .RST_N(rst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_o), .FRAME_MARKER(fm), .LINE_PULSE(lp),
    .EXTERNAL_DISPLAY_CLOCK_IN(external_display_clock_in), .SEGMENT_OUTPUTS(seg), .FIRST_COMMON_OUTPUT(first_common_output),
    .LINE_ADDRESS(line), .ICON_OUT_A(ia), .ICON_OUT_B(ib));
  lsc_lcd_src SRC (.clk(clk), .go(go), .frm(frm), .fm(fm), .lp(lp), .external_display_clock_in(external_display_clock_in));
  logic [2:0]   exa_d;

  // Pin history: an icon terminal on the external clock trails the pin by three edges
  always @(posedge clk)
    exa_d <= {exa_d[1:0], external_display_clock_in};

  task automatic print_verdict();
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t got %0h exp %0h", $time, g, e);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    // No cycle count assumed; only the watchdog ends a hung wait
    while (wait_o !== 1'b0)
    begin
      @(posedge clk);
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic scan(input logic f);
    go <= 1'b1;
    frm <= f;
    @(posedge clk);
    go <= 1'b0;
    repeat (24) @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (6000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  initial
  begin
    {rst_n, rd, wr, go, frm, addr, wd, err_total, checked} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk(seg, 0);
    chk(line, 0);
    chk(wait_o, 1);
    @(posedge clk);
    foreach (rows[i])
    begin
      bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 0);
      chk(q, rows[i].e);
    end
    bus(1, `LSC_REG_START, 5);
    bus(1, `LSC_REG_CTRL, 8'h08);
    bus(1, `LSC_REG_XADDR, 0);
    bus(1, `LSC_REG_YADDR, 5);
    for (int i = 0; i < 16; i++)
      bus(1, `LSC_REG_DATA, i == 0);
    scan(1);
    chk(line, 5);
    chk(seg, 128'h1);
    chk(first_common_output, 1);
    bus(1, `LSC_REG_XADDR, 0);
    chk(line, 5);
    bus(0, `LSC_REG_DATA, 0);
    bus(0, `LSC_REG_DATA, 0);
    chk(q, 32'h01);
    bus(0, `LSC_REG_XADDR, 0);
    chk(q, 32'h02);
    foreach (mc[i])
    begin
      bus(1, `LSC_REG_CTRL, mc[i]);
      scan(1);
      chk(seg, me[i]);
    end
    scan(0);
    chk(line, 6);
    bus(1, `LSC_REG_START, 8'h3F);
    scan(1);
    chk(line, 8'h3F);
    scan(0);
    chk(line, 0);
    scan(0);
    chk(first_common_output, 0);
    chk(line, 1);
    bus(0, `LSC_REG_STATUS, 0);
    chk(q[7:0], 8'h01);
    bus(1, `LSC_REG_CTRL, 8'h10);
    bus(1, `LSC_REG_YADDR, 8'h42);
    bus(1, `LSC_REG_DATA, 8'hAA);
    bus(0, `LSC_REG_YADDR, 0);
    chk(q, 0);
    bus(1, `LSC_REG_CTRL, 8'h00);
    bus(1, `LSC_REG_YADDR, 8'h42);
    bus(0, `LSC_REG_DATA, 0);
    bus(0, `LSC_REG_DATA, 0);
    chk(q, 32'hAA);
    bus(1, `LSC_REG_CTRL, 8'hA0);
    repeat (10) @(posedge clk);
    chk(ia ^ ib, 1);
    bus(1, `LSC_REG_CTRL, 8'hE0);
    repeat (20) @(posedge clk);
    chk(ia ^ ib, 1);
    chk(ia, exa_d[2]);
    bus(1, `LSC_REG_CTRL, 8'h60);
    repeat (6) @(posedge clk);
    chk(ia ^ ib, 0);
    bus(1, `LSC_REG_CTRL, 8'h00);
    repeat (4) @(posedge clk);
    chk({ia, ib}, 0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(seg, 0);
    chk(line, 0);
    print_verdict();
  end
endmodule
